// ==== src/tfad_task_file_address_decoder.sv ====
// Task-file address decoder: decodes the memory window and the direct-disk
// I/O map, steers byte lanes and sequences the sector data port.
// Assumes all pins are synchronous to ref_clk_i and that the sector buffer
// presents its head word at all times and never overflows or runs dry.
`timescale 1ns/1ns

module tfad_task_file_address_decoder #(
  parameter int unsigned DATA_W = tfad_pkg::DATA_W
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic [tfad_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                        attribute_select_n_i,
  input  wire logic                        low_byte_enable_n_i,
  input  wire logic                        high_byte_enable_n_i,
  input  wire logic                        mem_read_strobe_n_i,
  input  wire logic                        mem_write_strobe_n_i,
  input  wire logic                        io_read_strobe_n_i,
  input  wire logic                        io_write_strobe_n_i,
  input  wire logic                        direct_disk_mode_i,
  input  wire logic [DATA_W-1:0]           data_i,
  output logic      [DATA_W-1:0]           data_o,
  output logic                             data_oe_o,
  output logic                             io_word_ack_n_o,
  input  wire logic [DATA_W-1:0]           buf_head_i,
  output logic                             buf_pop_o,
  output logic                             buf_push_o,
  output logic      [DATA_W-1:0]           buf_push_data_o,
  input  wire logic [7:0]                  error_i,
  input  wire logic [7:0]                  status_i,
  input  wire logic [7:0]                  drive_address_i,
  input  wire logic                        cmd_done_i,
  input  wire logic                        cmd_ok_i,
  input  wire logic [7:0]                  sectors_left_i,
  output logic      [7:0]                  features_o,
  output logic      [7:0]                  sector_number_o,
  output logic      [7:0]                  cylinder_low_o,
  output logic      [7:0]                  cylinder_high_o,
  output logic      [7:0]                  card_head_o,
  output logic      [tfad_pkg::COUNT_W-1:0] sector_total_o,
  output logic      [7:0]                  command_o,
  output logic                             command_strobe_o,
  output logic      [7:0]                  device_control_o
);

  // ****************************************************************
  // Parameter check.
  // ****************************************************************
  if (DATA_W != 16) begin : g_width_check
    $error("tfad: the data port is exactly 16 bits wide");
  end

  // ****************************************************************
  // Functions.
  // ****************************************************************
  // Zero written to the sector count stands for a full 256 sectors.
  function automatic logic [tfad_pkg::COUNT_W-1:0] sc_total(
    input logic [7:0] v
  );
    sc_total = (v == tfad_pkg::TF_RESET) ? tfad_pkg::SECTORS_ZERO
                                         : {1'b0, v};
  endfunction

  function automatic logic is_data_off(input logic [3:0] o);
    is_data_off = (o == tfad_pkg::OFF_DATA) || (o == tfad_pkg::OFF_ERR_FEAT)
               || (o == tfad_pkg::OFF_DUP_EVEN) || (o == tfad_pkg::OFF_DUP_ODD);
  endfunction

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic       rd_act_q;
  logic       wr_act_q;
  logic       got_even;
  logic       got_odd;
  logic [7:0] wr_even;
  logic [7:0] wr_odd;
  logic [7:0] sector_count;

  // ****************************************************************
  // Access detection.
  // ****************************************************************
  wire lo_en   = !low_byte_enable_n_i;
  wire hi_en   = !high_byte_enable_n_i;
  wire both_en = lo_en && hi_en;
  wire any_en  = lo_en || hi_en;

  wire rd_act = direct_disk_mode_i ? !io_read_strobe_n_i : !mem_read_strobe_n_i;
  wire wr_act = direct_disk_mode_i ? !io_write_strobe_n_i : !mem_write_strobe_n_i;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  // Memory window: A10 folds the upper 1 KByte onto offsets 8 and 9.
  wire       win_hi  = addr_i[tfad_pkg::ADDR_WIN_BIT];
  wire [3:0] mem_off = win_hi ? {3'b100, addr_i[0]} : addr_i[3:0];

  // Direct-disk map: the high enable alone reaches only offsets E and F.
  wire       dd_hi_ok = (addr_i[2:1] == tfad_pkg::DD_HIGH_SEL);
  wire [3:0] dd_off   = (hi_en && !lo_en) ? {tfad_pkg::DD_HIGH_BASE, addr_i[0]}
                                          : {1'b0, addr_i[2:0]};
  wire       dd_word  = both_en && (addr_i[2:1] == 2'b00);
  wire       dd_valid = lo_en || dd_hi_ok;

  wire [3:0] off      = direct_disk_mode_i ? dd_off : mem_off;
  wire       valid    = direct_disk_mode_i ? dd_valid : attribute_select_n_i;

  // Lane classes; direct-disk byte accesses always use the low lanes.
  wire sel_word = direct_disk_mode_i ? dd_word : both_en;
  wire sel_lo   = direct_disk_mode_i ? !dd_word : (lo_en && !hi_en);
  wire sel_hi   = !direct_disk_mode_i && hi_en && !lo_en;

  // ****************************************************************
  // Data-port classification.
  // ****************************************************************
  // Word access at 0, 1, 8 or 9 is the data word, never error/features.
  wire d_word = sel_word && is_data_off(off);
  // Low-lane byte at 0 or 8 steps through the buffer even then odd.
  wire d_seq  = sel_lo && ((off == tfad_pkg::OFF_DATA)
                        || (off == tfad_pkg::OFF_DUP_EVEN));
  // Offset 9 on the low lanes, or 8 and 9 on the upper lanes, is odd only.
  wire d_odd  = (sel_lo && (off == tfad_pkg::OFF_DUP_ODD))
             || (sel_hi && ((off == tfad_pkg::OFF_DUP_EVEN)
                         || (off == tfad_pkg::OFF_DUP_ODD)));
  wire d_any  = d_word || d_seq || d_odd;

  // A sequential byte is odd once the even half has been moved.
  wire byte_is_odd = d_odd || (d_seq && got_even);
  wire byte_is_evn = d_seq && !got_even;
  wire word_done   = (byte_is_odd && got_even) || (byte_is_evn && got_odd);

  // ****************************************************************
  // Register selection.
  // ****************************************************************
  // Upper lanes reach the odd register at or above the given address.
  wire [3:0] lo_reg = sel_word ? {off[3:1], 1'b0} : off;
  wire [3:0] hi_reg = {off[3:1], 1'b1};

  logic [7:0] lo_rd;
  logic [7:0] hi_rd;

  // Readable task-file bytes, error first, packed one byte per register.
  wire [63:0] tf_regs = {drive_address_i, status_i, card_head_o, cylinder_high_o,
                         cylinder_low_o, sector_number_o, sector_count, error_i};

  function automatic logic [7:0] reg_rd(input logic [3:0] o, input logic [63:0] r);
    unique case (o)
      tfad_pkg::OFF_ERR_FEAT,
      tfad_pkg::OFF_DUP_ERR:   reg_rd = r[7:0];
      tfad_pkg::OFF_SEC_COUNT: reg_rd = r[15:8];
      tfad_pkg::OFF_SEC_NUM:   reg_rd = r[23:16];
      tfad_pkg::OFF_CYL_LOW:   reg_rd = r[31:24];
      tfad_pkg::OFF_CYL_HIGH:  reg_rd = r[39:32];
      tfad_pkg::OFF_CARD_HEAD: reg_rd = r[47:40];
      tfad_pkg::OFF_STAT_CMD,
      tfad_pkg::OFF_ALT_CTL:   reg_rd = r[55:48];
      tfad_pkg::OFF_DRV_ADDR:  reg_rd = r[63:56];
      default:                 reg_rd = tfad_pkg::TF_RESET;
    endcase
  endfunction

  assign lo_rd = reg_rd(lo_reg, tf_regs);
  assign hi_rd = reg_rd(hi_reg, tf_regs);

  // ****************************************************************
  // Read data steering.
  // ****************************************************************
  wire [7:0]  d_byte  = byte_is_odd ? buf_head_i[15:8] : buf_head_i[7:0];
  // Word reads put even data on the low lanes, odd on the high lanes.
  wire [15:0] d_rdata = d_word ? buf_head_i
                      : sel_hi ? {d_byte, 8'h00} : {8'h00, d_byte};
  wire [15:0] r_rdata = sel_word ? {hi_rd, lo_rd}
                      : sel_hi ? {hi_rd, 8'h00} : {8'h00, lo_rd};
  wire [15:0] rdata   = d_any ? d_rdata : r_rdata;

  wire rd_go = rd_act && !rd_act_q && any_en && valid;
  wire wr_go = wr_act && !wr_act_q && any_en && valid;

  // ****************************************************************
  // Write data steering.
  // ****************************************************************
  wire [7:0]  w_byte  = sel_hi ? data_i[15:8] : data_i[7:0];
  wire [15:0] w_word  = byte_is_odd ? {w_byte, wr_even} : {wr_odd, w_byte};
  wire [15:0] next_push_data = d_word ? data_i : w_word;

  // Register writes: which register each lane reaches this cycle.
  wire        w_lo    = wr_go && !d_any && !sel_hi;
  wire        w_hi    = wr_go && !d_any && (sel_hi || sel_word);
  wire [3:0]  wlo_reg = lo_reg;
  wire [3:0]  whi_reg = hi_reg;

  // Mask of the registers that the write lanes reach this cycle, one bit per register.
  wire [15:0] w_sel = ({16{w_lo}} & (16'h0001 << wlo_reg))
                    | ({16{w_hi}} & (16'h0001 << whi_reg));

  // Picks the byte that reaches a register; the high lane wins on overlap.
  function automatic logic [7:0] pick(
    input logic       hi_en_w,
    input logic [3:0] hi_o,
    input logic [3:0] want,
    input logic [15:0] d
  );
    pick = (hi_en_w && (hi_o == want)) ? d[15:8] : d[7:0];
  endfunction

  wire h_feat = w_sel[tfad_pkg::OFF_ERR_FEAT] || w_sel[tfad_pkg::OFF_DUP_ERR];
  wire h_sc   = w_sel[tfad_pkg::OFF_SEC_COUNT];
  wire h_sn   = w_sel[tfad_pkg::OFF_SEC_NUM];
  wire h_cl   = w_sel[tfad_pkg::OFF_CYL_LOW];
  wire h_ch   = w_sel[tfad_pkg::OFF_CYL_HIGH];
  wire h_hd   = w_sel[tfad_pkg::OFF_CARD_HEAD];
  wire h_cmd  = w_sel[tfad_pkg::OFF_STAT_CMD];
  wire h_ctl  = w_sel[tfad_pkg::OFF_ALT_CTL];

  wire [7:0] feat_b = (w_hi && (whi_reg == tfad_pkg::OFF_ERR_FEAT
                             || whi_reg == tfad_pkg::OFF_DUP_ERR))
                    ? data_i[15:8] : data_i[7:0];

  // Sector count: a finished command loads zero or the sectors still owed.
  wire [7:0] next_sc = cmd_done_i ? (cmd_ok_i ? tfad_pkg::TF_RESET : sectors_left_i)
                     : pick(w_hi, whi_reg, tfad_pkg::OFF_SEC_COUNT, data_i);
  wire       sc_load = cmd_done_i || h_sc;

  // ****************************************************************
  // Strobe edge history and read output.
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_act_q  <= 1'b0;
      wr_act_q  <= 1'b0;
      data_o    <= tfad_pkg::WORD_RESET;
      data_oe_o <= 1'b0;
    end else begin
      rd_act_q  <= rd_act;
      wr_act_q  <= wr_act;
      if (rd_go) begin
        data_o <= rdata;
      end
      data_oe_o <= rd_act && (data_oe_o || rd_go);
    end
  end

  // 16-bit capability is signalled only for the direct-disk data offset.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      io_word_ack_n_o <= 1'b1;
    end else begin
      io_word_ack_n_o <= !(direct_disk_mode_i && (addr_i[2:0] == 3'b000));
    end
  end

  // ****************************************************************
  // Sector buffer sequencing.
  // ****************************************************************
  // Only pop, push and the push data leave this block; no address reaches the buffer.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      got_even        <= 1'b0;
      got_odd         <= 1'b0;
      wr_even         <= tfad_pkg::TF_RESET;
      wr_odd          <= tfad_pkg::TF_RESET;
      buf_pop_o       <= 1'b0;
      buf_push_o      <= 1'b0;
      buf_push_data_o <= tfad_pkg::WORD_RESET;
    end else begin
      buf_pop_o  <= rd_go && (d_word || word_done);
      buf_push_o <= wr_go && (d_word || word_done);
      if (wr_go && (d_word || word_done)) begin
        buf_push_data_o <= next_push_data;
      end
      if (wr_go && byte_is_evn) begin
        wr_even <= w_byte;
      end
      if (wr_go && byte_is_odd) begin
        wr_odd <= w_byte;
      end
      if ((rd_go || wr_go) && (d_word || word_done)) begin
        got_even <= 1'b0;
        got_odd  <= 1'b0;
      end else if (rd_go || wr_go) begin
        got_even <= got_even || byte_is_evn;
        got_odd  <= got_odd || byte_is_odd;
      end
    end
  end

  // ****************************************************************
  // Task-file registers.
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      features_o       <= tfad_pkg::TF_RESET;
      sector_count     <= tfad_pkg::TF_RESET;
      sector_total_o   <= tfad_pkg::SECTORS_ZERO;
      sector_number_o  <= tfad_pkg::TF_RESET;
      cylinder_low_o   <= tfad_pkg::TF_RESET;
      cylinder_high_o  <= tfad_pkg::TF_RESET;
      card_head_o      <= tfad_pkg::TF_RESET;
      command_o        <= tfad_pkg::TF_RESET;
      command_strobe_o <= 1'b0;
      device_control_o <= tfad_pkg::TF_RESET;
    end else begin
      if (h_feat) begin
        features_o <= feat_b;
      end
      if (sc_load) begin
        sector_count   <= next_sc;
        sector_total_o <= sc_total(next_sc);
      end
      if (h_sn) begin
        sector_number_o <= pick(w_hi, whi_reg, tfad_pkg::OFF_SEC_NUM, data_i);
      end
      if (h_cl) begin
        cylinder_low_o <= pick(w_hi, whi_reg, tfad_pkg::OFF_CYL_LOW, data_i);
      end
      if (h_ch) begin
        cylinder_high_o <= pick(w_hi, whi_reg, tfad_pkg::OFF_CYL_HIGH, data_i);
      end
      if (h_hd) begin
        card_head_o <= pick(w_hi, whi_reg, tfad_pkg::OFF_CARD_HEAD, data_i);
      end
      if (h_cmd) begin
        command_o <= pick(w_hi, whi_reg, tfad_pkg::OFF_STAT_CMD, data_i);
      end
      command_strobe_o <= h_cmd;
      if (h_ctl) begin
        device_control_o <= pick(w_hi, whi_reg, tfad_pkg::OFF_ALT_CTL, data_i);
      end
    end
  end

endmodule

// ==== src/tfad_pkg.sv ====
// Constants for the task-file address decoder: offsets, widths, reset
// values and the sector-count rule.
// Assumes nothing of its surroundings; every design file uses it by scope.
package tfad_pkg;

  // ****************************************************************
  // Widths.
  // ****************************************************************
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned ADDR_W  = 11;
  localparam int unsigned OFF_W   = 4;
  localparam int unsigned COUNT_W = 9;

  // ****************************************************************
  // Task-file offsets.
  // ****************************************************************
  localparam logic [3:0] OFF_DATA      = 4'h0;
  localparam logic [3:0] OFF_ERR_FEAT  = 4'h1;
  localparam logic [3:0] OFF_SEC_COUNT = 4'h2;
  localparam logic [3:0] OFF_SEC_NUM   = 4'h3;
  localparam logic [3:0] OFF_CYL_LOW   = 4'h4;
  localparam logic [3:0] OFF_CYL_HIGH  = 4'h5;
  localparam logic [3:0] OFF_CARD_HEAD = 4'h6;
  localparam logic [3:0] OFF_STAT_CMD  = 4'h7;
  localparam logic [3:0] OFF_DUP_EVEN  = 4'h8;
  localparam logic [3:0] OFF_DUP_ODD   = 4'h9;
  localparam logic [3:0] OFF_DUP_ERR   = 4'hD;
  localparam logic [3:0] OFF_ALT_CTL   = 4'hE;
  localparam logic [3:0] OFF_DRV_ADDR  = 4'hF;

  // ****************************************************************
  // Address fields.
  // ****************************************************************
  localparam int unsigned ADDR_WIN_BIT = 10;
  localparam logic [1:0]  DD_HIGH_SEL  = 2'b11;
  localparam logic [2:0]  DD_HIGH_BASE = 3'b111;

  // ****************************************************************
  // Reset values and the sector-count rule.
  // ****************************************************************
  localparam logic [7:0]  TF_RESET      = 8'h00;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [8:0]  SECTORS_ZERO  = 9'h100;

endpackage

// ==== tb/tfad_checker.sv ====
// Assertion checker for the task-file decoder host port.
// Assumes it is bound to the decoder and every input follows ref_clk_i.
`timescale 1ns/1ns
module tfad_checker (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic [10:0] addr_i,
  input wire logic        attribute_select_n_i,
  input wire logic        low_byte_enable_n_i,
  input wire logic        high_byte_enable_n_i,
  input wire logic        mem_read_strobe_n_i,
  input wire logic        mem_write_strobe_n_i,
  input wire logic        io_read_strobe_n_i,
  input wire logic        direct_disk_mode_i,
  input wire logic [15:0] data_i,
  input wire logic [15:0] data_o,
  input wire logic        io_word_ack_n_o,
  input wire logic [15:0] buf_head_i,
  input wire logic        buf_pop_o,
  input wire logic        buf_push_o,
  input wire logic [15:0] buf_push_data_o,
  input wire logic [7:0]  error_i,
  input wire logic [7:0]  status_i,
  input wire logic        cmd_done_i,
  input wire logic        cmd_ok_i,
  input wire logic [7:0]  sectors_left_i,
  input wire logic [8:0]  sector_total_o,
  input wire logic [7:0]  command_o,
  input wire logic        command_strobe_o
);
  // ****************************************************************
  // Leading-edge detection of the strobes, as the port takes them.
  // ****************************************************************
  logic rd_q;
  logic wr_q;
  logic io_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {rd_q, wr_q, io_q} <= 3'h7;
    end else begin
      {rd_q, wr_q, io_q} <= {mem_read_strobe_n_i, mem_write_strobe_n_i, io_read_strobe_n_i};
    end
  end
  wire       en  = !low_byte_enable_n_i || !high_byte_enable_n_i;
  wire       mm  = !direct_disk_mode_i && attribute_select_n_i && en;
  wire       rd  = mm && !mem_read_strobe_n_i && rd_q;
  wire       wr  = mm && !mem_write_strobe_n_i && wr_q;
  wire       io  = direct_disk_mode_i && en && !io_read_strobe_n_i && io_q;
  wire       w16 = !low_byte_enable_n_i && !high_byte_enable_n_i;
  wire       lo8 = !low_byte_enable_n_i && high_byte_enable_n_i;
  wire       hi8 = low_byte_enable_n_i && !high_byte_enable_n_i;
  wire       tf  = !addr_i[10];
  wire [3:0] off = addr_i[3:0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ****************************************************************
  // Port properties.
  // ****************************************************************
  property p_word_pop; rd && w16 && (addr_i[10] || addr_i[2:1] == 2'h0)
    |=> buf_pop_o && data_o == $past(buf_head_i); endproperty
  a_word_pop: assert property (p_word_pop) else $error("word read missed the head");
  property p_err_hi; rd && hi8 && tf && off == 4'h0
    |=> data_o == {$past(error_i), 8'h00} && !buf_pop_o; endproperty
  a_err_hi: assert property (p_err_hi) else $error("upper byte at 0 not error");
  property p_gap; rd && lo8 && tf && off >= 4'hA && off <= 4'hC
    |=> data_o == 16'h0000 && !buf_pop_o; endproperty
  a_gap: assert property (p_gap) else $error("undecoded offset read not zero");
  property p_status; rd && lo8 && tf && off == 4'h7
    |=> data_o == {8'h00, $past(status_i)}; endproperty
  a_status: assert property (p_status) else $error("status read wrong");
  property p_win_push; wr && w16 && addr_i[10]
    |=> buf_push_o && buf_push_data_o == $past(data_i); endproperty
  a_win_push: assert property (p_win_push) else $error("window word write lost");
  property p_pop_cause; buf_pop_o |-> $past(rd || io); endproperty
  a_pop_cause: assert property (p_pop_cause) else $error("pop without a read");
  property p_cmd; wr && lo8 && tf && off == 4'h7
    |=> command_strobe_o && {8'h00, command_o} == ($past(data_i) & 16'h00ff); endproperty
  a_cmd: assert property (p_cmd) else $error("command write not strobed");
  property p_done; cmd_done_i |=> sector_total_o == (($past(cmd_ok_i) ||
    $past(sectors_left_i) == 8'h00) ? 9'h100 : {1'b0, $past(sectors_left_i)}); endproperty
  a_done: assert property (p_done) else $error("sector total after completion wrong");
  property p_ack; direct_disk_mode_i
    |=> io_word_ack_n_o == (($past(addr_i) & 11'h007) != 11'h000); endproperty
  a_ack: assert property (p_ack) else $error("word acknowledge wrong");
endmodule

bind tfad_task_file_address_decoder tfad_checker tfad_checker_inst (
  .ref_clk_i, .rst_b_i, .addr_i, .attribute_select_n_i, .low_byte_enable_n_i,
  .high_byte_enable_n_i, .mem_read_strobe_n_i, .mem_write_strobe_n_i, .io_read_strobe_n_i,
  .direct_disk_mode_i, .data_i, .data_o, .io_word_ack_n_o, .buf_head_i, .buf_pop_o,
  .buf_push_o, .buf_push_data_o, .error_i, .status_i, .cmd_done_i, .cmd_ok_i,
  .sectors_left_i, .sector_total_o, .command_o, .command_strobe_o
);

// ==== tb/tfad_buffer_model.sv ====
// Sector buffer model: a show-ahead word stream for reads and a push log.
// Assumes pops and pushes are one-cycle pulses on ref_clk_i.
`timescale 1ns/1ns
module tfad_buffer_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        pop_i,
  input  wire logic        push_i,
  input  wire logic [15:0] push_data_i,
  output logic      [15:0] head_o,
  output logic      [7:0]  pops_o,
  output logic      [7:0]  pushes_o,
  output logic      [15:0] last_push_o
);
  // ****************************************************************
  // Sequential stream: the head only moves on a pop, never by address.
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pops_o      <= 8'h00;
      pushes_o    <= 8'h00;
      last_push_o <= 16'h0000;
    end else begin
      pops_o   <= pops_o + 8'(pop_i);
      pushes_o <= pushes_o + 8'(push_i);
      if (push_i) begin
        last_push_o <= push_data_i;
      end
    end
  end
  assign head_o = {pops_o ^ 8'h5a, pops_o};
endmodule

// ==== tb/task_file_address_decoder_tb.sv ====
// Self-checking bench for the task-file decoder with a sector buffer model.
// Assumes the checker is bound to the decoder by its own file.
`timescale 1ns/1ns
module task_file_address_decoder_tb;
  localparam logic [1:0] BOTH = 2'h0;
  localparam logic [1:0] HI   = 2'h1;
  localparam logic [1:0] LO   = 2'h2;
  logic clk = 1'b0, rst_b = 1'b0, att_n = 1'b1, lo_n = 1'b1, hi_n = 1'b1, dd = 1'b0;
  logic mrd_n = 1'b1, mwr_n = 1'b1, ird_n = 1'b1, iwr_n = 1'b1, done = 1'b0, ok = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [15:0] wdata = 16'h0000, rdata, head, pdata, lastp;
  logic [7:0]  err_v = 8'h00, stat_v = 8'h00, drv_v = 8'h00, left = 8'h00;
  logic [7:0]  feat, card, cmd, pops, pushes;
  logic [8:0]  total;
  logic        ack_n, pop, push, oe;
  int          errors = 0, num_checks = 0, nw = 0;
  always #2 clk = ~clk;
  tfad_task_file_address_decoder tfad_task_file_address_decoder_inst (
    .ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .attribute_select_n_i(att_n),
    .low_byte_enable_n_i(lo_n), .high_byte_enable_n_i(hi_n), .mem_read_strobe_n_i(mrd_n),
    .mem_write_strobe_n_i(mwr_n), .io_read_strobe_n_i(ird_n), .io_write_strobe_n_i(iwr_n),
    .direct_disk_mode_i(dd), .data_i(wdata), .data_o(rdata), .data_oe_o(oe),
    .io_word_ack_n_o(ack_n), .buf_head_i(head), .buf_pop_o(pop), .buf_push_o(push),
    .buf_push_data_o(pdata), .error_i(err_v), .status_i(stat_v), .drive_address_i(drv_v),
    .cmd_done_i(done), .cmd_ok_i(ok), .sectors_left_i(left), .features_o(feat),
    .sector_number_o(), .cylinder_low_o(), .cylinder_high_o(), .card_head_o(card),
    .sector_total_o(total), .command_o(cmd), .command_strobe_o(), .device_control_o());
  tfad_buffer_model tfad_buffer_model_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .pop_i(pop),
    .push_i(push), .push_data_i(pdata), .head_o(head), .pops_o(pops), .pushes_o(pushes),
    .last_push_o(lastp));
  // ****************************************************************
  // Expectations, checking and host cycles.
  // ****************************************************************
  function automatic logic [15:0] word(input int n);
    return {8'(n) ^ 8'h5a, 8'(n)};
  endfunction
  function automatic logic [15:0] lane(input logic [1:0] e, input logic [7:0] b);
    return (e == HI) ? {b, 8'h00} : {8'h00, b};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [10:0] a, input logic [1:0] e,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    {hi_n, lo_n} <= e;
    wdata <= d;
    {mrd_n, mwr_n, ird_n, iwr_n} <= {dd | wr, dd | !wr, !dd | wr, !dd | !wr};
    @(posedge clk);
    #1 q = rdata;
    @(posedge clk);
    {mrd_n, mwr_n, ird_n, iwr_n} <= 4'hf;
    #1;
  endtask
  task automatic bpair(input logic [10:0] a1, input logic [1:0] e1, input logic [10:0] a2,
                       input logic [1:0] e2, input bit odd1);
    logic [15:0] w;
    logic [15:0] q;
    w = word(nw);
    acc(1'b0, a1, e1, 16'h0000, q);
    check("first byte", q, lane(e1, odd1 ? w[15:8] : w[7:0]));
    acc(1'b0, a2, e2, 16'h0000, q);
    check("second byte", q, lane(e2, odd1 ? w[7:0] : w[15:8]));
    nw++;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    logic [15:0] q;
    logic [15:0] d;
    logic [10:0] a;
    logic [7:0]  v;
    void'($urandom(47));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    {err_v, stat_v, drv_v} <= 24'($urandom);
    #1 check("reset total", {7'h00, total}, 16'h0100);
    for (int i = 0; i < 12; i++) begin
      a = 11'($urandom);
      if (!a[10]) a[2:1] = 2'h0;
      acc(1'b0, a, BOTH, 16'h0000, q);
      check("word read", q, word(nw));
      nw++;
    end
    // Offset 9 is byte-read twice in a row, across the second and third pairs.
    bpair(11'h000, LO, 11'h3f0, LO, 1'b0);
    bpair(11'h008, LO, 11'h009, LO, 1'b0);
    bpair(11'h009, LO, 11'h008, LO, 1'b1);
    bpair(11'h008, LO, 11'h009, HI, 1'b0);
    bpair(11'h5f2, LO, 11'h6f1, LO, 1'b0);
    @(posedge clk);
    att_n <= 1'b0;
    v = pops;
    acc(1'b0, 11'h008, BOTH, 16'h0000, q);
    check("ignored read", {8'h00, pops}, {8'h00, v});
    att_n <= 1'b1;
    for (int o = 2; o < 7; o++) begin
      v = 8'($urandom_range(255, 1));
      a = {1'b0, 6'($urandom), 4'(o)};
      acc(1'b1, a, LO, {8'h00, v}, q);
      acc(1'b0, a, LO, 16'h0000, q);
      check("task reg", q, {8'h00, v});
    end
    check("card head", {8'h00, card}, {8'h00, v});
    acc(1'b1, 11'h002, LO, 16'h0000, q);
    check("zero count", {7'h00, total}, 16'h0100);
    for (int k = 0; k < 2; k++) begin
      v = 8'($urandom_range(255, 1));
      @(posedge clk);
      done <= 1'b1;
      ok   <= (k == 0);
      left <= v;
      @(posedge clk);
      done <= 1'b0;
      #1 check("done total", {7'h00, total}, (k == 0) ? 16'h0100 : {8'h00, v});
    end
    acc(1'b0, 11'h000, HI, 16'h0000, q);
    check("error upper", q, {err_v, 8'h00});
    acc(1'b0, 11'h00d, LO, 16'h0000, q);
    check("error dup", q, {8'h00, err_v});
    d = 16'($urandom);
    acc(1'b1, 11'h000, HI, d, q);
    check("features", {8'h00, feat}, {8'h00, d[15:8]});
    v = pushes;
    acc(1'b1, 11'h00a, BOTH, d, q);
    acc(1'b0, 11'h00c, LO, 16'h0000, q);
    check("gap read", q, 16'h0000);
    check("gap push", {8'h00, pushes}, {8'h00, v});
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      a = 11'($urandom);
      if (!a[10]) a[2:1] = 2'h0;
      acc(1'b1, a, BOTH, d, q);
      check("word push", lastp, d);
    end
    acc(1'b1, 11'h000, LO, {8'h00, d[7:0]}, q);
    acc(1'b1, 11'h000, LO, {8'h00, d[15:8]}, q);
    check("byte push", lastp, d);
    acc(1'b1, 11'h007, LO, {8'h00, v}, q);
    check("command", {8'h00, cmd}, {8'h00, v});
    @(posedge clk);
    dd <= 1'b1;
    acc(1'b0, 11'h007, LO, 16'h0000, q);
    check("io status", q, {8'h00, stat_v});
    acc(1'b0, 11'h006, HI, 16'h0000, q);
    check("io alt status", q, {8'h00, stat_v});
    acc(1'b0, 11'h007, HI, 16'h0000, q);
    check("io drive", q, {8'h00, drv_v});
    acc(1'b0, 11'h000, BOTH, 16'h0000, q);
    check("io word", q, word(nw));
    check("io ack", {15'h0000, ack_n}, 16'h0000);
    check("io drive enable", {15'h0000, oe}, 16'h0001);
    finish_test();
  end
endmodule
